// file: design/pif_map.vh
`ifndef PIF_MAP_VH
`define PIF_MAP_VH

// ----------------------------------------------------------------------
// Register indexes (byte address is four times the index)
// ----------------------------------------------------------------------
`define PIF_IDX_TIMER      10'h088
`define PIF_IDX_SERIAL     10'h098
`define PIF_IDX_TWO_WIRE   10'h0dc
`define PIF_IDX_SPI_STATUS 10'h0e1
`define PIF_IDX_SPI_DATA   10'h0e2
`define PIF_IDX_IRQ_ENABLE 10'h0f0
`define PIF_IDX_IRQ_STATUS 10'h0f1
`define PIF_IDX_IRQ_CLEAR  10'h0f2
`define PIF_IDX_CONTROL    10'h0f3

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define PIF_TIMER_ONE_BIT  7
`define PIF_TIMER_ZERO_BIT 5
`define PIF_EXT_PIN_BIT    1
`define PIF_SER_TX_BIT     1
`define PIF_SER_RX_BIT     0
`define PIF_SPI_DONE_BIT   7
`define PIF_SPI_FAULT_BIT  4
`define PIF_TWI_SI_BIT     7
`define PIF_CTRL_GLOBAL    7
`define PIF_CTRL_EDGE      0

// ----------------------------------------------------------------------
// Event numbering in the status, enable and clear registers
// ----------------------------------------------------------------------
`define PIF_EV_TIMER0      0
`define PIF_EV_TIMER1      1
`define PIF_EV_EXT         2
`define PIF_EV_TX          3
`define PIF_EV_RX          4
`define PIF_EV_SPI         5
`define PIF_EV_TWI         6
`define PIF_EV_COUNT       7

// ----------------------------------------------------------------------
// Constants and reset values
// ----------------------------------------------------------------------
`define PIF_TWI_NO_INFO    8'hf8
`define PIF_SER_MODE0      2'h0
`define PIF_ADR_ALIGNED    2'h0
`define PIF_BYTE_RESET     8'h00
`define PIF_ENABLE_RESET   7'h00
`define PIF_WORD_ZERO      32'h00000000
`define PIF_PAD_ZERO       24'h000000

`endif

// file: design/pif_flag_cell.v
`timescale 1ns/10ps
module pif_flag_cell (
   input  wire clock,
   input  wire resetn,
   input  wire setEvent,
   input  wire hwClear,
   input  wire writeEn,
   input  wire writeVal,
   output reg  flag
);
   // Hardware set wins over any clear in the same cycle
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         flag <= 1'b0;
      end else if (setEvent) begin
         flag <= 1'b1;
      end else if (hwClear) begin
         flag <= 1'b0;
      end else if (writeEn) begin
         flag <= writeVal;
      end
   end
endmodule

// file: design/pif_edge_detect.v
`timescale 1ns/10ps
module pif_edge_detect (
   input  wire clock,
   input  wire resetn,
   input  wire pinLevel,
   input  wire risingSel,
   output wire edgePulse
);
   reg lastLevel;
   reg primed;

   // No edge is reported before one sample has been taken
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         lastLevel <= 1'b0;
         primed    <= 1'b0;
      end else begin
         lastLevel <= pinLevel;
         primed    <= 1'b1;
      end
   end

   assign edgePulse = primed & (risingSel ? (pinLevel & ~lastLevel)
                                          : (~pinLevel & lastLevel));
endmodule

// file: design/pif_core.v
// Notes on behaviour
// R01: Timer-one flag, timer control bit 7, writable
// R02: Timer-zero flag, timer control bit 5, writable
// R03: External pin flag, bit 1, read-only
// R04: Transmit flag set at bit-8 end or stop start
// R05: Transmit flag bit 1, cleared only by software
// R06: Receive flag set at bit-8 end or stop middle
// R07: Receive flag bit 0, cleared only by software
// R08: SPI done flag bit 7 set on transfer end
// R09: SPI done cleared by reading status then data
// R10: Two-wire flag set on entering status states
// R11: Status code F8h never sets two-wire flag
// R12: Two-wire flag cleared by zero, one ignored
// R13: Pin edge sets flag when both enables on
// R14: Vectoring to pin interrupt clears its flag
// R15: Flag, own enable, global enable form request
`timescale 1ns/10ps
`include "pif_map.vh"
module pif_core (
   input  wire        clock,
   input  wire        resetn,
   // Wishbone classic slave
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   input  wire        wb_we_i,
   input  wire [11:0] wb_adr_i,
   input  wire [3:0]  wb_sel_i,
   input  wire [31:0] wb_dat_i,
   output reg  [31:0] wb_dat_o,
   output reg         wb_ack_o,
   // Peripheral events
   input  wire        timerOneOverflow,
   input  wire        timerZeroOverflow,
   input  wire        ext_pin_interrupt,
   input  wire        cpuVectorExt,
   input  wire [1:0]  serialMode,
   input  wire        txBit8End,
   input  wire        txStopStart,
   input  wire        rxBit8End,
   input  wire        rxStopMiddle,
   input  wire        spiTransferDone,
   input  wire        spi_fault_flag,
   input  wire [7:0]  spiRxData,
   input  wire        twiStateEnter,
   input  wire [7:0]  twiStatusCode,
   // Requests toward the CPU core
   output wire [6:0]  cpuRequest,
   output wire        irq
);

   // -------------------------------------------------------------------
   // Bus decode
   // -------------------------------------------------------------------
   wire [9:0] reqIdx;
   wire       aligned;
   wire       busTake;
   wire       writeLow;
   wire       readTake;
   wire       wrTimer;
   wire       wrSerial;
   wire       wrTwoWire;
   wire       wrEnable;
   wire       wrClear;
   wire       wrControl;
   wire       rdSpiStatus;
   wire       rdSpiData;

   assign reqIdx   = wb_adr_i[11:2];
   assign aligned  = (wb_adr_i[1:0] == `PIF_ADR_ALIGNED);
   // A transfer takes effect at the edge where ack is seen high
   assign busTake  = wb_cyc_i & wb_stb_i & wb_ack_o & aligned;
   assign writeLow = busTake & wb_we_i & wb_sel_i[0];
   assign readTake = busTake & ~wb_we_i;

   assign wrTimer     = writeLow & (reqIdx == `PIF_IDX_TIMER);
   assign wrSerial    = writeLow & (reqIdx == `PIF_IDX_SERIAL);
   assign wrTwoWire   = writeLow & (reqIdx == `PIF_IDX_TWO_WIRE);
   assign wrEnable    = writeLow & (reqIdx == `PIF_IDX_IRQ_ENABLE);
   assign wrClear     = writeLow & (reqIdx == `PIF_IDX_IRQ_CLEAR);
   assign wrControl   = writeLow & (reqIdx == `PIF_IDX_CONTROL);
   assign rdSpiStatus = readTake & (reqIdx == `PIF_IDX_SPI_STATUS);
   assign rdSpiData   = readTake & (reqIdx == `PIF_IDX_SPI_DATA);

   // -------------------------------------------------------------------
   // Software control registers
   // -------------------------------------------------------------------
   reg  [7:0] control;
   reg  [6:0] irqEnable;
   wire       global_irq_enable;
   wire       ext_pin_enable;

   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         control   <= `PIF_BYTE_RESET;
         irqEnable <= `PIF_ENABLE_RESET;
      end else begin
         if (wrControl) begin
            control[`PIF_CTRL_GLOBAL] <= wb_dat_i[`PIF_CTRL_GLOBAL];
            control[`PIF_CTRL_EDGE]   <= wb_dat_i[`PIF_CTRL_EDGE];
         end
         if (wrEnable) begin
            irqEnable <= wb_dat_i[6:0];
         end
      end
   end

   assign global_irq_enable = control[`PIF_CTRL_GLOBAL];
   assign ext_pin_enable    = irqEnable[`PIF_EV_EXT];

   // -------------------------------------------------------------------
   // Event qualification
   // -------------------------------------------------------------------
   wire extEdge;
   wire extSet;
   wire txSet;
   wire rxSet;
   wire twiSet;
   wire serMode0;

   pif_edge_detect u_ext_edge (
      .clock     (clock),
      .resetn    (resetn),
      .pinLevel  (ext_pin_interrupt),
      .risingSel (control[`PIF_CTRL_EDGE]),
      .edgePulse (extEdge)
   );

   assign extSet   = extEdge & ext_pin_enable & global_irq_enable; // [R13]
   assign serMode0 = (serialMode == `PIF_SER_MODE0);
   assign txSet    = serMode0 ? txBit8End : txStopStart;           // [R04]
   assign rxSet    = serMode0 ? rxBit8End : rxStopMiddle;          // [R06]
   assign twiSet   = twiStateEnter &
                     (twiStatusCode != `PIF_TWI_NO_INFO);     // [R10] [R11]

   // -------------------------------------------------------------------
   // Request flags
   // -------------------------------------------------------------------
   wire timer_one_request;
   wire timer_zero_request;
   wire ext_pin_request;
   wire serial_tx_request;
   wire serial_rx_request;
   wire spi_done_flag;
   wire twiFlag;
   wire spiClear;
   reg  spiStatusSeen;

   pif_flag_cell u_timer_one (                                   // [R01]
      .clock    (clock),
      .resetn   (resetn),
      .setEvent (timerOneOverflow),
      .hwClear  (1'b0),
      .writeEn  (wrTimer),
      .writeVal (wb_dat_i[`PIF_TIMER_ONE_BIT]),
      .flag     (timer_one_request)
   );

   pif_flag_cell u_timer_zero (                                  // [R02]
      .clock    (clock),
      .resetn   (resetn),
      .setEvent (timerZeroOverflow),
      .hwClear  (1'b0),
      .writeEn  (wrTimer),
      .writeVal (wb_dat_i[`PIF_TIMER_ZERO_BIT]),
      .flag     (timer_zero_request)
   );

   // Read-only; cleared when the CPU vectors to the pin service
   pif_flag_cell u_ext_pin (                               // [R03] [R14]
      .clock    (clock),
      .resetn   (resetn),
      .setEvent (extSet),
      .hwClear  (cpuVectorExt),
      .writeEn  (1'b0),
      .writeVal (1'b0),
      .flag     (ext_pin_request)
   );

   pif_flag_cell u_serial_tx (                                   // [R05]
      .clock    (clock),
      .resetn   (resetn),
      .setEvent (txSet),
      .hwClear  (1'b0),
      .writeEn  (wrSerial),
      .writeVal (wb_dat_i[`PIF_SER_TX_BIT]),
      .flag     (serial_tx_request)
   );

   pif_flag_cell u_serial_rx (                                   // [R07]
      .clock    (clock),
      .resetn   (resetn),
      .setEvent (rxSet),
      .hwClear  (1'b0),
      .writeEn  (wrSerial),
      .writeVal (wb_dat_i[`PIF_SER_RX_BIT]),
      .flag     (serial_rx_request)
   );

   pif_flag_cell u_spi_done (                                    // [R08]
      .clock    (clock),
      .resetn   (resetn),
      .setEvent (spiTransferDone),
      .hwClear  (spiClear),
      .writeEn  (1'b0),
      .writeVal (1'b0),
      .flag     (spi_done_flag)
   );

   // Only a written zero clears; a written one leaves the flag alone
   pif_flag_cell u_two_wire (                                    // [R12]
      .clock    (clock),
      .resetn   (resetn),
      .setEvent (twiSet),
      .hwClear  (1'b0),
      .writeEn  (wrTwoWire & ~wb_dat_i[`PIF_TWI_SI_BIT]),
      .writeVal (1'b0),
      .flag     (twiFlag)
   );

   // -------------------------------------------------------------------
   // SPI completion clear: status read arms, data read clears
   // -------------------------------------------------------------------
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         spiStatusSeen <= 1'b0;
      end else if (rdSpiStatus & spi_done_flag) begin
         spiStatusSeen <= 1'b1;                                  // [R09]
      end else if (rdSpiData | spiTransferDone) begin
         spiStatusSeen <= 1'b0;
      end
   end

   assign spiClear = rdSpiData & spiStatusSeen;                  // [R09]

   // -------------------------------------------------------------------
   // Requests toward the CPU core
   // -------------------------------------------------------------------
   wire [6:0] flagVector;

   assign flagVector[`PIF_EV_TIMER0] = timer_zero_request;
   assign flagVector[`PIF_EV_TIMER1] = timer_one_request;
   assign flagVector[`PIF_EV_EXT]    = ext_pin_request;
   assign flagVector[`PIF_EV_TX]     = serial_tx_request;
   assign flagVector[`PIF_EV_RX]     = serial_rx_request;
   assign flagVector[`PIF_EV_SPI]    = spi_done_flag;
   assign flagVector[`PIF_EV_TWI]    = twiFlag;

   assign cpuRequest = flagVector & irqEnable &
                       {`PIF_EV_COUNT{global_irq_enable}};       // [R15]

   // -------------------------------------------------------------------
   // Sticky event status with write-one clear
   // -------------------------------------------------------------------
   wire [6:0] eventVector;
   wire [6:0] irqStatus;

   assign eventVector[`PIF_EV_TIMER0] = timerZeroOverflow;
   assign eventVector[`PIF_EV_TIMER1] = timerOneOverflow;
   assign eventVector[`PIF_EV_EXT]    = extSet;
   assign eventVector[`PIF_EV_TX]     = txSet;
   assign eventVector[`PIF_EV_RX]     = rxSet;
   assign eventVector[`PIF_EV_SPI]    = spiTransferDone;
   assign eventVector[`PIF_EV_TWI]    = twiSet;

   genvar gi;
   generate
      for (gi = 0; gi < `PIF_EV_COUNT; gi = gi + 1) begin : g_status
         pif_flag_cell u_status (
            .clock    (clock),
            .resetn   (resetn),
            .setEvent (eventVector[gi]),
            .hwClear  (wrClear & wb_dat_i[gi]),
            .writeEn  (1'b0),
            .writeVal (1'b0),
            .flag     (irqStatus[gi])
         );
      end
   endgenerate

   assign irq = |(irqStatus & irqEnable);

   // -------------------------------------------------------------------
   // Read data
   // -------------------------------------------------------------------
   reg [7:0] next_readByte;

   always @* begin
      next_readByte = `PIF_BYTE_RESET;
      case (reqIdx)
         `PIF_IDX_TIMER: begin
            next_readByte[`PIF_TIMER_ONE_BIT]  = timer_one_request;
            next_readByte[`PIF_TIMER_ZERO_BIT] = timer_zero_request;
            next_readByte[`PIF_EXT_PIN_BIT]    = ext_pin_request;
         end
         `PIF_IDX_SERIAL: begin
            next_readByte[`PIF_SER_TX_BIT] = serial_tx_request;
            next_readByte[`PIF_SER_RX_BIT] = serial_rx_request;
         end
         `PIF_IDX_TWO_WIRE: begin
            next_readByte[`PIF_TWI_SI_BIT] = twiFlag;
         end
         `PIF_IDX_SPI_STATUS: begin
            next_readByte[`PIF_SPI_DONE_BIT]  = spi_done_flag;
            next_readByte[`PIF_SPI_FAULT_BIT] = spi_fault_flag;
         end
         `PIF_IDX_SPI_DATA: begin
            next_readByte = spiRxData;
         end
         `PIF_IDX_IRQ_ENABLE: begin
            next_readByte = {1'b0, irqEnable};
         end
         `PIF_IDX_IRQ_STATUS: begin
            next_readByte = {1'b0, irqStatus};
         end
         `PIF_IDX_CONTROL: begin
            next_readByte = control;
         end
         default: begin
            next_readByte = `PIF_BYTE_RESET;
         end
      endcase
      if (!aligned) begin
         next_readByte = `PIF_BYTE_RESET;
      end
   end

   // -------------------------------------------------------------------
   // Acknowledge: one wait cycle, then ack for one cycle
   // -------------------------------------------------------------------
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= `PIF_WORD_ZERO;
      end else begin
         wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
         if (wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_we_i) begin
            wb_dat_o <= {`PIF_PAD_ZERO, next_readByte};
         end else begin
            wb_dat_o <= `PIF_WORD_ZERO;
         end
      end
   end

endmodule

// file: bench/pif_event_model.sv
`timescale 1ns/10ps
module pif_event_model (
   input  logic       clock,
   input  logic       resetn,
   input  logic [7:0] fireMask,
   output logic [7:0] pulses
);
   // ----
   // Peripheral events
   // ----
   // Each requested event leaves one edge later and stays high as long as it is requested
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         pulses <= 8'h00;
      end else begin
         pulses <= fireMask;
      end
   end
endmodule

// file: bench/pif_core_properties.sv
`timescale 1ns/10ps
module pif_core_properties (
   input logic        clock,
   input logic        resetn,
   input logic        wb_cyc_i,
   input logic        wb_stb_i,
   input logic [31:0] wb_dat_o,
   input logic        wb_ack_o,
   input logic        ext_pin_interrupt,
   input logic        cpuVectorExt,
   input logic        twiStateEnter,
   input logic [7:0]  twiStatusCode,
   input logic [6:0]  cpuRequest,
   input logic        irq
);
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);
   // ----
   // Bus answer and sticky requests
   // ----
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_f8;
      twiStateEnter && twiStatusCode == 8'hf8 && !cpuRequest[6] && !wb_ack_o;
   endsequence
   sequence s_vec;
      cpuVectorExt && $stable(ext_pin_interrupt) && !wb_ack_o;
   endsequence
   property p_hold(b);
      b && !wb_ack_o |=> b;
   endproperty
   a_ack_next: assert property (s_req |=> wb_ack_o)
      else $error("ack not one cycle after request");
   a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h00000000)
      else $error("read data not zero outside ack");
   a_timer_one_hold: assert property (p_hold(cpuRequest[1]))
      else $error("timer one request dropped");
   a_tx_flag_hold: assert property (p_hold(cpuRequest[3]))
      else $error("transmit request dropped");
   a_rx_flag_hold: assert property (p_hold(cpuRequest[4]))
      else $error("receive request dropped");
   a_spi_flag_hold: assert property (p_hold(cpuRequest[5]))
      else $error("spi request dropped without a read");
   a_twi_flag_hold: assert property (p_hold(cpuRequest[6]))
      else $error("two-wire request dropped");
   a_twi_no_info: assert property (s_f8 |=> !cpuRequest[6])
      else $error("two-wire request set by code f8");
   a_pin_vec_clear: assert property (s_vec |=> !cpuRequest[2])
      else $error("pin request kept after vectoring");
   a_irq_sticky: assert property (irq && !wb_ack_o |=> irq)
      else $error("irq dropped without a write");
endmodule

bind pif_core pif_core_properties i_props (
   .clock(clock), .resetn(resetn), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .ext_pin_interrupt(ext_pin_interrupt), .cpuVectorExt(cpuVectorExt),
   .twiStateEnter(twiStateEnter), .twiStatusCode(twiStatusCode),
   .cpuRequest(cpuRequest), .irq(irq));

// file: bench/tb_top.sv
`timescale 1ns/10ps
module tb_top;
   localparam logic [11:0] A_TMR = 12'h220;
   localparam logic [11:0] A_SER = 12'h260;
   localparam logic [11:0] A_TWI = 12'h370;
   localparam logic [11:0] A_SPS = 12'h384;
   localparam logic [11:0] A_SPD = 12'h388;
   localparam logic [11:0] A_ENA = 12'h3c0;
   localparam logic [11:0] A_STA = 12'h3c4;
   localparam logic [11:0] A_CLR = 12'h3c8;
   localparam logic [11:0] A_CTL = 12'h3cc;
   typedef struct {
      logic [7:0]  ev;
      logic [1:0]  mode;
      logic [7:0]  code;
      logic [11:0] adr;
      logic [7:0]  exp;
   } pif_row_t;
   logic        clock = 1'b0, resetn = 1'b0;
   logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
   logic [3:0]  sel = 4'h0, selUse = 4'h1;
   logic [11:0] adr = 12'h000;
   logic [31:0] wdat = 32'h0, rdat, q;
   logic        pin = 1'b0, vec = 1'b0, fault = 1'b0, irq;
   logic [1:0]  mode = 2'h0;
   logic [7:0]  code = 8'h00, fireMask = 8'h00, pulses;
   logic [7:0]  rxData = 8'h5a;
   logic [6:0]  cpuRequest;
   int          miscompares = 0, checks_done = 0, cycles = 0;
   pif_row_t    rows [13];

   pif_event_model i_model (.clock(clock), .resetn(resetn),
      .fireMask(fireMask), .pulses(pulses));
   pif_core i_dut (.clock(clock), .resetn(resetn), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .timerOneOverflow(pulses[0]), .timerZeroOverflow(pulses[1]),
      .ext_pin_interrupt(pin), .cpuVectorExt(vec), .serialMode(mode),
      .txBit8End(pulses[2]), .txStopStart(pulses[3]),
      .rxBit8End(pulses[4]), .rxStopMiddle(pulses[5]),
      .spiTransferDone(pulses[6]), .spi_fault_flag(fault),
      .spiRxData(rxData), .twiStateEnter(pulses[7]),
      .twiStatusCode(code), .cpuRequest(cpuRequest), .irq(irq));

   always #4 clock = ~clock;

   // ----
   // Shared tasks
   // ----
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch t=%0t seen=%h expected=%h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic [11:0] a, input logic w,
                      input logic [7:0] d);
      @(posedge clock);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      sel <= selUse;
      adr <= a;
      wdat <= {24'h0, d};
      // Only the cycle watchdog ends a wait for the answer
      @(posedge clock);
      while (ack !== 1'b1) begin
         @(posedge clock);
      end
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [7:0] e);
      bus(a, 1'b0, 8'h00);
      chk(q, {24'h0, e});
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      bus(a, 1'b1, d);
   endtask
   // Event pulse reaches the block one edge after the request
   task automatic fire(input logic [7:0] m);
      @(posedge clock);
      fireMask <= m;
      @(posedge clock);
      fireMask <= 8'h00;
      repeat (2) @(posedge clock);
   endtask

   always @(posedge clock) begin
      cycles++;
      if (cycles == 5000) begin
         miscompares++;
         wrap_up;
      end
   end

   // ----
   // Main sequence
   // ----
   initial begin
      rows = '{
         '{8'h01, 2'h0, 8'h00, A_TMR, 8'h80},
         '{8'h02, 2'h0, 8'h00, A_TMR, 8'h20},
         '{8'h04, 2'h0, 8'h00, A_SER, 8'h02},
         '{8'h08, 2'h0, 8'h00, A_SER, 8'h00},
         '{8'h08, 2'h1, 8'h00, A_SER, 8'h02},
         '{8'h04, 2'h3, 8'h00, A_SER, 8'h00},
         '{8'h10, 2'h0, 8'h00, A_SER, 8'h01},
         '{8'h20, 2'h0, 8'h00, A_SER, 8'h00},
         '{8'h20, 2'h2, 8'h00, A_SER, 8'h01},
         '{8'h10, 2'h2, 8'h00, A_SER, 8'h00},
         '{8'h40, 2'h0, 8'h00, A_SPS, 8'h80},
         '{8'h80, 2'h0, 8'h08, A_TWI, 8'h80},
         '{8'h80, 2'h0, 8'hf8, A_TWI, 8'h00}
      };
      repeat (2) @(posedge clock);
      resetn <= 1'b1;
      rd(A_TMR, 8'h00);
      rd(A_SER, 8'h00);
      rd(A_SPS, 8'h00);
      wr(A_CTL, 8'h80);
      wr(A_ENA, 8'h7b);
      foreach (rows[i]) begin
         mode <= rows[i].mode;
         code <= rows[i].code;
         fire(rows[i].ev);
         rd(rows[i].adr, rows[i].exp);
         wr(A_TMR, 8'h00);
         wr(A_SER, 8'h00);
         wr(A_TWI, 8'h00);
         bus(A_SPS, 1'b0, 8'h00);
         bus(A_SPD, 1'b0, 8'h00);
      end
      wr(A_TMR, 8'hff);
      rd(A_TMR, 8'ha0);
      wr(A_TMR, 8'h00);
      // A write without the low byte lane must be ignored
      selUse = 4'he;
      wr(A_TMR, 8'ha0);
      selUse = 4'h1;
      rd(A_TMR, 8'h00);
      mode <= 2'h1;
      fire(8'h28);
      repeat (5) @(posedge clock);
      rd(A_SER, 8'h03);
      wr(A_SER, 8'h02);
      rd(A_SER, 8'h02);
      wr(A_SER, 8'h00);
      fault <= 1'b1;
      fire(8'h40);
      rd(A_SPD, 8'h5a);
      rd(A_SPS, 8'h90);
      rd(A_SPD, 8'h5a);
      rd(A_SPS, 8'h10);
      code <= 8'h60;
      fire(8'h80);
      wr(A_TWI, 8'h80);
      rd(A_TWI, 8'h80);
      wr(A_TWI, 8'h00);
      rd(A_TWI, 8'h00);
      wr(A_CLR, 8'h7f);
      pin <= 1'b1;
      repeat (3) @(posedge clock);
      rd(A_TMR, 8'h00);
      pin <= 1'b0;
      wr(A_CTL, 8'h81);
      wr(A_ENA, 8'h7f);
      pin <= 1'b1;
      repeat (3) @(posedge clock);
      rd(A_TMR, 8'h02);
      @(negedge clock);
      chk({24'h0, irq, cpuRequest}, 32'h84);
      @(posedge clock);
      vec <= 1'b1;
      @(posedge clock);
      vec <= 1'b0;
      rd(A_TMR, 8'h00);
      rd(A_STA, 8'h04);
      wr(A_CLR, 8'h04);
      @(negedge clock);
      chk({24'h0, irq, cpuRequest}, 32'h00);
      wr(A_ENA, 8'h00);
      fire(8'h02);
      chk({24'h0, irq, cpuRequest}, 32'h00);
      wr(A_ENA, 8'h01);
      @(negedge clock);
      chk({24'h0, irq, cpuRequest}, 32'h81);
      wr(A_CTL, 8'h01);
      @(negedge clock);
      chk({24'h0, irq, cpuRequest}, 32'h80);
      wr(12'h100, 8'hff);
      rd(12'h100, 8'h00);
      rd(A_CLR, 8'h00);
      rd(12'h221, 8'h00);
      @(posedge clock);
      resetn <= 1'b0;
      repeat (2) @(posedge clock);
      resetn <= 1'b1;
      rd(A_TMR, 8'h00);
      rd(A_ENA, 8'h00);
      wrap_up;
   end
endmodule
